/* File: core/coef_map.svh */
// address map constants for the coefficient block addressing logic
`ifndef COEF_MAP_SVH
`define COEF_MAP_SVH
`define COEF_WORDS 40
`define COEF_BLOCKS 5
`define COEF_BLK_WORDS 8
`define COEF_LAST_BLK 3'h4
`define COEF_TOP_IDX 3'h7
`define COEF_BOT_IDX 3'h0
`define BLK_IMPEDANCE_MATCH 3'h0
`define BLK_ECHO_CANCEL 3'h1
`define BLK_TONE_SCALING 3'h2
`define BLK_TRANSMIT 3'h3
`define BLK_RECEIVE 3'h4
`define TONE0_FREQ_ADDR 6'h14
`define TONE0_AMPL_ADDR 6'h15
`define TONE1_FREQ_ADDR 6'h16
`define TONE1_AMPL_ADDR 6'h17
`define RX_RESP_LAST_ADDR 6'h23
`endif

/* File: core/coef_pkg.sv */
// types for the coefficient block addressing logic
package coef_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WALK = 2'b10
  } walk_state_t;
  typedef logic [15:0] coef_word_t;
endpackage

/* File: core/coef_block_addr.sv */
// coefficient memory with block addressing and downward word walk
// How it works
// - forty words as five eight-word blocks
// - one command walks all eight block words
// - word index counts down 111 to 000
// - address is block code over word index
// - receive block holds gain and response words
// - channel 0 words 20 to 23 feed tone generators
`timescale 1ns/1ps
`include "coef_map.svh"
module coef_block_addr
  import coef_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // command from host control port
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [2:0] cmd_block_i,
  input wire logic [1:0] cmd_chan_i,
  // word stream
  input wire logic [15:0] wr_data_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  output logic busy_o,
  output logic [5:0] word_addr_o,
  output logic cmd_error_o,
  // tone coefficients of channel 0
  output logic [15:0] tone0_freq_o,
  output logic [15:0] tone0_ampl_o,
  output logic [15:0] tone1_freq_o,
  output logic [15:0] tone1_ampl_o
);
  walk_state_t state_ff, nxt_state;

  // walk context captured when a command is taken
  logic [2:0] blk_ff;
  logic [2:0] idx_ff;
  logic [1:0] chan_ff;
  logic wr_ff;

  // registered outputs
  logic [15:0] rd_data_ff;
  logic rd_valid_ff;
  logic err_ff;
  logic [15:0] t0f_ff;
  logic [15:0] t0a_ff;
  logic [15:0] t1f_ff;
  logic [15:0] t1a_ff;
  logic [5:0] addr_ff;
  logic busy_ff;

  // set once channel 0 tone block has been written; guards tone checks only
  logic tone_loaded_ff;

  // four banks of forty words, one per channel
  coef_word_t mem_ff [0:3][0:`COEF_WORDS-1];

  // codes above the last block are refused, never folded onto a real block
  wire cmd_ok = cmd_valid_i && (cmd_block_i <= `COEF_LAST_BLK);
  wire start = (state_ff == ST_IDLE) && cmd_ok;
  wire walking = (state_ff == ST_WALK);
  wire last_word = walking && (idx_ff == `COEF_BOT_IDX);

  // receive block: gain words on top, response words below, one walk for both
  wire [5:0] addr = {blk_ff, idx_ff};
  wire do_write = walking && wr_ff;
  wire tone_done = do_write && last_word && (chan_ff == 2'h0) && (blk_ff == `BLK_TONE_SCALING);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (start) nxt_state = ST_WALK;
      ST_WALK: if (last_word) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state_ff <= ST_IDLE;
      blk_ff <= 3'h0;
      idx_ff <= `COEF_TOP_IDX;
      chan_ff <= 2'h0;
      wr_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      err_ff <= cmd_valid_i && !cmd_ok && (state_ff == ST_IDLE);
      if (start) begin
        blk_ff <= cmd_block_i;
        chan_ff <= cmd_chan_i;
        wr_ff <= cmd_write_i;
        idx_ff <= `COEF_TOP_IDX;
      end else if (walking) begin
        idx_ff <= idx_ff - 3'h1;
      end
    end
  end

  // memory has no reset: coefficients are loaded by the host after power up
  always_ff @(posedge sys_clk_i) begin
    if (do_write) mem_ff[chan_ff][addr] <= wr_data_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rd_data_ff <= 16'h0;
      rd_valid_ff <= 1'b0;
      t0f_ff <= 16'h0;
      t0a_ff <= 16'h0;
      t1f_ff <= 16'h0;
      t1a_ff <= 16'h0;
    end else begin
      rd_valid_ff <= walking && !wr_ff;
      if (walking && !wr_ff) rd_data_ff <= mem_ff[chan_ff][addr];
      t0f_ff <= mem_ff[0][`TONE0_FREQ_ADDR];
      t0a_ff <= mem_ff[0][`TONE0_AMPL_ADDR];
      t1f_ff <= mem_ff[0][`TONE1_FREQ_ADDR];
      t1a_ff <= mem_ff[0][`TONE1_AMPL_ADDR];
    end
  end

  // address output registered so it lines up with read data
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      addr_ff <= 6'h0;
      busy_ff <= 1'b0;
    end else begin
      addr_ff <= walking ? addr : addr_ff;
      busy_ff <= (nxt_state == ST_WALK);
    end
  end

  // memory keeps its words over reset, but this flag does not: conservative
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      tone_loaded_ff <= 1'b0;
    end else if (tone_done) begin
      tone_loaded_ff <= 1'b1;
    end
  end

  assign rd_data_o = rd_data_ff;
  assign rd_valid_o = rd_valid_ff;
  assign busy_o = busy_ff;
  assign word_addr_o = addr_ff;
  assign cmd_error_o = err_ff;
  assign tone0_freq_o = t0f_ff;
  assign tone0_ampl_o = t0a_ff;
  assign tone1_freq_o = t1f_ff;
  assign tone1_ampl_o = t1a_ff;

  // walk lasts exactly eight cycles
  a_walk_length: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    start |=> walking [*8] ##1 !walking) else $error("walk not eight words");
  a_idx_top_first: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    start |=> idx_ff == 3'h7) else $error("walk not starting at top word");
  a_idx_down: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    walking && !last_word |=> idx_ff == $past(idx_ff) - 3'h1) else $error("index not down");
  a_addr_form: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    start |=> addr[5:3] == $past(cmd_block_i)) else $error("block bits wrong");
  a_block_range: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    walking |-> blk_ff <= 3'h4) else $error("block out of range");
  a_bad_block: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    cmd_valid_i && cmd_block_i > 3'h4 && !walking |=> cmd_error_o && !busy_o)
    else $error("bad block accepted");
  a_rx_shared: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    start && cmd_block_i == 3'h4 |=> ##4 addr == 6'h23) else $error("response words missed");
  a_chan_held: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    walking && !last_word |=> $stable(chan_ff)) else $error("channel changed mid walk");

  // tone words are unknown until written, so these wait for the tone block
  a_tone_word: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    tone_loaded_ff |=> tone0_freq_o == $past(mem_ff[0][`TONE0_FREQ_ADDR]))
    else $error("tone word wrong");
  a_tone_ampl0: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    tone_loaded_ff |=> tone0_ampl_o == $past(mem_ff[0][`TONE0_AMPL_ADDR]))
    else $error("tone0 amplitude wrong");
  a_tone_freq1: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    tone_loaded_ff |=> tone1_freq_o == $past(mem_ff[0][`TONE1_FREQ_ADDR]))
    else $error("tone1 frequency wrong");
  a_tone_ampl1: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    tone_loaded_ff |=> tone1_ampl_o == $past(mem_ff[0][`TONE1_AMPL_ADDR]))
    else $error("tone1 amplitude wrong");

  // busy is registered from the next state, so it covers exactly the walk
  a_busy_level: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    start |=> busy_o [*8] ##1 !busy_o)
    else $error("busy not eight cycles");

  // read words trail the walk by one cycle
  a_read_pulses: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    start && !cmd_write_i |=> ##1 rd_valid_o [*8] ##1 !rd_valid_o)
    else $error("read words not eight");
  a_write_quiet: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    start && cmd_write_i |=> ##1 !rd_valid_o [*8])
    else $error("read during write walk");
  a_idle_quiet: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !walking |=> !rd_valid_o)
    else $error("read word while idle");
  a_walk_end: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    last_word |=> !walking)
    else $error("walk ran past bottom word");

  // the address output follows the walked word one cycle late
  a_addr_out: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    walking |=> word_addr_o == $past(addr))
    else $error("word address output wrong");

  // main scenarios
  c_write_walk: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) start && cmd_write_i);
  c_read_walk: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) start && !cmd_write_i);
  c_rx_block: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) start && cmd_block_i == 3'h4);
  c_bad_block: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) cmd_error_o);
  c_tone_load: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) tone_done);
endmodule // coef_block_addr

/* File: dv/host_model.sv */
// host side model issuing coefficient block commands
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk_i,
  // command and write words
  output logic valid_o,
  output logic write_o,
  output logic [2:0] block_o,
  output logic [1:0] chan_o,
  output logic [15:0] data_o
);
  initial begin
    valid_o = 1'b0;
    write_o = 1'b0;
    block_o = 3'h0;
    chan_o = 2'h0;
    data_o = 16'h0000;
  end
  function automatic logic [15:0] pat(logic [1:0] c, logic [2:0] b, logic [2:0] i);
    return {8'hc3, c, b, i};
  endfunction
  // called at a falling edge; block code and channel go out, no word address
  task automatic cmd(logic w, logic [2:0] b, logic [1:0] c);
    valid_o = 1'b1;
    write_o = w;
    block_o = b;
    chan_o = c;
    @(negedge clk_i);
    valid_o = 1'b0;
    for (int i = 7; i >= 0 && w; i--) begin
      data_o = pat(c, b, 3'(i));
      @(negedge clk_i);
    end
    // released line flips so a stale word never matches
    data_o = ~data_o;
  endtask
endmodule // host_model

/* File: dv/testbench.sv */
// self-checking bench for the coefficient block addressing
`timescale 1ns/1ps
module testbench;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic vld, wr, busy, rv, err;
  logic [2:0] blk;
  logic [1:0] ch;
  logic [15:0] wd, rd, t0f, t0a, t1f, t1a;
  logic [5:0] wa;
  int n_mismatch = 0;
  int checks_done = 0;
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  host_model i_host (.clk_i(sys_clk_i), .valid_o(vld), .write_o(wr), .block_o(blk),
    .chan_o(ch), .data_o(wd));
  coef_block_addr i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cmd_valid_i(vld),
    .cmd_write_i(wr), .cmd_block_i(blk), .cmd_chan_i(ch), .wr_data_i(wd), .rd_data_o(rd),
    .rd_valid_o(rv), .busy_o(busy), .word_addr_o(wa), .cmd_error_o(err),
    .tone0_freq_o(t0f), .tone0_ampl_o(t0a), .tone1_freq_o(t1f), .tone1_ampl_o(t1a));
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic walk_all(logic w);
    for (int c = 0; c < 4; c++) for (int b = 0; b < 5; b++) begin
      // read: returns one negedge after the take; write: after the last word
      i_host.cmd(w, 3'(b), 2'(c));
      if (!w) chk("busy", 16'h1, 16'(busy));
      for (int i = 7; i >= 0 && !w; i--) begin
        @(negedge sys_clk_i);
        chk("valid", 16'h1, 16'(rv));
        chk("data", i_host.pat(2'(c), 3'(b), 3'(i)), rd);
        chk("addr", {10'h0, 3'(b), 3'(i)}, 16'(wa));
      end
      if (w) chk("no_read", 16'h0, 16'(rv));
      chk("busy_end", 16'h0, 16'(busy));
    end
    $display("test walk write=%0d done", w);
  endtask
  task automatic tones();
    chk("tone0f", i_host.pat(2'h0, 3'h2, 3'h4), t0f);
    chk("tone0a", i_host.pat(2'h0, 3'h2, 3'h5), t0a);
    chk("tone1f", i_host.pat(2'h0, 3'h2, 3'h6), t1f);
    chk("tone1a", i_host.pat(2'h0, 3'h2, 3'h7), t1a);
    $display("test tones done");
  endtask
  task automatic bad_block();
    for (int b = 5; b < 8; b++) begin
      i_host.cmd(1'b0, 3'(b), 2'h1);
      chk("err", 16'h1, 16'(err));
      chk("idle", 16'h0, 16'(busy));
      @(negedge sys_clk_i);
      chk("err_end", 16'h0, 16'(err));
    end
    $display("test bad_block done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    walk_all(1'b1);
    walk_all(1'b0);
    tones();
    bad_block();
    report_and_stop();
  end
  // about 376 cycles expected; a hang is ended at 3000 cycles, well above this
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    n_mismatch++;
    report_and_stop();
  end
endmodule // testbench
